/* File: hdl/tcc_defs.vh */
// register map, field positions, clock source and response codes and value constants for the timer core
`ifndef TCC_DEFS_VH
`define TCC_DEFS_VH

`define TCC_ADDR_CTRL 4'h0
`define TCC_ADDR_CNTH 4'h4
`define TCC_ADDR_CNTL 4'h8
`define TCC_ADDR_MOD 4'hC

`define TCC_BIT_OVF 7
`define TCC_BIT_OIE 6
`define TCC_BIT_CAS 5
`define TCC_CLKS_HI 4
`define TCC_CLKS_LO 3
`define TCC_PS_HI 2
`define TCC_PS_LO 0

`define TCC_CLKS_OFF 2'h0
`define TCC_CLKS_BUS 2'h1
`define TCC_CLKS_FIX 2'h2
`define TCC_CLKS_EXT 2'h3

`define TCC_RESP_OKAY 2'h0
`define TCC_RESP_SLVERR 2'h2

`define TCC_CNT_ZERO 16'h0000
`define TCC_CNT_ONE 16'h0001
`define TCC_BYTE_ZERO 8'h00
`define TCC_PRE_ONE 7'h01
`define TCC_WORD_ZERO 32'h0000_0000
`define TCC_CNT_MAX 16'hFFFF
`define TCC_PRE_ZERO 7'h00
`define TCC_PS_ZERO 3'h0
`define TCC_NIB_ZERO 4'h0

`define TCC_LO_HI 7
`define TCC_LO_LO 0
`define TCC_HI_HI 15
`define TCC_HI_LO 8

`endif

/* File: hdl/tcc_timer_core.v */
// 16-bit timer core: control/status, clock select, prescaler, counter, AXI4-Lite slave
//
// Behaviour
// - overflow flag sets on wrap to zero
// - flag clears by read-while-set then write zero
// - new overflow restarts the clear sequence
// - writing one keeps flag; reset clears it
// - interrupt request when flag and enable set
// - center-align select makes counter count up/down
// - clock source field chooses prescaler input
// - fixed clock acts as bus clock without pll
// - external clock synchronised to bus clock
// - prescale divides by two to field power
// - prescaler follows source sync and selection
// - new prescale applies next system clock cycle
// - counter byte read latches both bytes coherently
// - reset or control write restarts read latch
// - counter byte write clears counter and latch
// - reset clears both counter bytes
// - debug halt freezes counter value
// - debug halt freezes read latch state
// - control or counter writes in debug halt still restart latch
// - counter wraps after modulus; zero free-runs
`timescale 1ns/1ps
`default_nettype none
`include "tcc_defs.vh"

module tcc_timer_core (
    input wire mclk_i,
    input wire rst_i,
    input wire debug_halt_i,
    input wire fixed_clk_tick_i,
    input wire fixed_clk_present_i,
    input wire ext_clk_i,
    output wire overflow_irq_o,
    output wire count_down_o,
    output wire center_align_o,
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready
);

    // control fields, modulus, counter, direction, clear arming and read latch
    reg overflow_flag_q;
    reg overflow_irq_enable_q;
    reg center_align_select_q;
    reg [1:0] clock_source_field_q;
    reg [2:0] prescale_field_q;
    reg [15:0] modulus_value_q;
    reg [15:0] count_q;
    reg down_q;
    reg clear_armed_q;
    reg latch_valid_q;
    reg [15:0] latch_q;

    // write channel capture: address and data may arrive in either order
    reg aw_held_q;
    reg [3:0] aw_addr_q;
    reg w_held_q;
    reg [31:0] w_data_q;
    reg [3:0] w_strb_q;

    // a held half refuses the next one until the response is taken
    assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
    assign s_axi_wready = !w_held_q && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    wire aw_fire = s_axi_awvalid && s_axi_awready;
    wire w_fire = s_axi_wvalid && s_axi_wready;
    wire [3:0] wr_addr = aw_held_q ? aw_addr_q : s_axi_awaddr;
    wire [31:0] wr_data = w_held_q ? w_data_q : s_axi_wdata;
    wire [3:0] wr_strb = w_held_q ? w_strb_q : s_axi_wstrb;
    wire wr_go = (aw_held_q || aw_fire) && (w_held_q || w_fire);
    wire rd_go = s_axi_arvalid && s_axi_arready;

    function addr_known;
        input [3:0] a;
        begin
            addr_known = (a == `TCC_ADDR_CTRL) || (a == `TCC_ADDR_CNTH) ||
                (a == `TCC_ADDR_CNTL) || (a == `TCC_ADDR_MOD);
        end
    endfunction

    // either counter byte; shared by the write clear and the read latch
    function cnt_addr;
        input [3:0] a;
        begin
            cnt_addr = (a == `TCC_ADDR_CNTH) || (a == `TCC_ADDR_CNTL);
        end
    endfunction

    wire wr_ctrl = wr_go && (wr_addr == `TCC_ADDR_CTRL) && wr_strb[0];
    wire wr_cnt = wr_go && cnt_addr(wr_addr);
    wire wr_mod = wr_go && (wr_addr == `TCC_ADDR_MOD);
    wire rd_ctrl = rd_go && (s_axi_araddr == `TCC_ADDR_CTRL);
    wire rd_cnt = rd_go && cnt_addr(s_axi_araddr);

    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            aw_held_q <= 1'b0;
            aw_addr_q <= `TCC_NIB_ZERO;
            w_held_q <= 1'b0;
            w_data_q <= `TCC_WORD_ZERO;
            w_strb_q <= `TCC_NIB_ZERO;
        end else if (wr_go) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
        end else begin
            if (aw_fire) begin
                aw_held_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (w_fire) begin
                w_held_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
        end
    end

    // response waits for both halves
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `TCC_RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= addr_known(wr_addr) ? `TCC_RESP_OKAY : `TCC_RESP_SLVERR;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // external clock: three stages, edge counted once stages two and three agree;
    // the pin must stay below a quarter of the bus rate or edges are lost
    reg [2:0] ext_sync_q;
    reg ext_level_q;
    wire [2:0] ext_sync_d = {ext_sync_q[1:0], ext_clk_i};
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_ext_sync
            always @(posedge mclk_i or posedge rst_i) begin
                if (rst_i) begin
                    ext_sync_q[gi] <= 1'b0;
                end else begin
                    ext_sync_q[gi] <= ext_sync_d[gi];
                end
            end
        end
    endgenerate
    wire ext_agree = (ext_sync_q[1] == ext_sync_q[2]);
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            ext_level_q <= 1'b0;
        end else if (ext_agree) begin
            ext_level_q <= ext_sync_q[2];
        end
    end
    wire ext_rise = ext_agree && ext_sync_q[2] && !ext_level_q;

    // source selection ahead of the prescaler
    reg src_tick;
    always @* begin
        case (clock_source_field_q)
            `TCC_CLKS_BUS: src_tick = 1'b1;
            `TCC_CLKS_FIX: src_tick = fixed_clk_present_i ? fixed_clk_tick_i : 1'b1;
            `TCC_CLKS_EXT: src_tick = ext_rise;
            default: src_tick = 1'b0;
        endcase
    end

    // prescaler divides the selected source; registers read directly so a new
    // factor takes hold on the very next cycle
    reg [6:0] pre_q;
    wire [6:0] pre_mask = (`TCC_PRE_ONE << prescale_field_q) - `TCC_PRE_ONE;
    wire pre_tick = src_tick && ((pre_q & pre_mask) == pre_mask);
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            pre_q <= `TCC_PRE_ZERO;
        end else if (src_tick && !debug_halt_i) begin
            pre_q <= pre_q + `TCC_PRE_ONE;
        end
    end

    wire cnt_tick = pre_tick && !debug_halt_i;
    wire at_top = (modulus_value_q == `TCC_CNT_ZERO) ? (count_q == `TCC_CNT_MAX) :
        (count_q >= modulus_value_q);
    reg ovf_event;
    reg [15:0] count_d;
    reg down_d;
    // center mode turns at the top and overflows on reaching zero going down
    always @* begin
        count_d = count_q;
        down_d = down_q;
        ovf_event = 1'b0;
        if (cnt_tick) begin
            if (center_align_select_q) begin
                if (!down_q) begin
                    if (at_top) begin
                        down_d = 1'b1;
                        count_d = count_q - `TCC_CNT_ONE;
                    end else begin
                        count_d = count_q + `TCC_CNT_ONE;
                    end
                end else if (count_q == `TCC_CNT_ONE || count_q == `TCC_CNT_ZERO) begin
                    down_d = 1'b0;
                    count_d = `TCC_CNT_ZERO;
                    ovf_event = 1'b1;
                end else begin
                    count_d = count_q - `TCC_CNT_ONE;
                end
            end else begin
                down_d = 1'b0;
                if (at_top) begin
                    count_d = `TCC_CNT_ZERO;
                    ovf_event = 1'b1;
                end else begin
                    count_d = count_q + `TCC_CNT_ONE;
                end
            end
        end
        if (wr_cnt) begin
            count_d = `TCC_CNT_ZERO;
            down_d = 1'b0;
        end
    end

    wire clear_write = wr_ctrl && !wr_data[`TCC_BIT_OVF] && clear_armed_q && !ovf_event;

    // counter and direction
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            count_q <= `TCC_CNT_ZERO;
            down_q <= 1'b0;
        end else begin
            count_q <= count_d;
            down_q <= down_d;
        end
    end

    // a fresh overflow beats a pending clear so no event is lost
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            overflow_flag_q <= 1'b0;
            clear_armed_q <= 1'b0;
        end else if (ovf_event) begin
            overflow_flag_q <= 1'b1;
            clear_armed_q <= 1'b0;
        end else if (clear_write) begin
            overflow_flag_q <= 1'b0;
            clear_armed_q <= 1'b0;
        end else if (rd_ctrl && overflow_flag_q) begin
            clear_armed_q <= 1'b1;
        end
    end

    // control fields
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            overflow_irq_enable_q <= 1'b0;
            center_align_select_q <= 1'b0;
            clock_source_field_q <= `TCC_CLKS_OFF;
            prescale_field_q <= `TCC_PS_ZERO;
        end else if (wr_ctrl) begin
            overflow_irq_enable_q <= wr_data[`TCC_BIT_OIE];
            center_align_select_q <= wr_data[`TCC_BIT_CAS];
            clock_source_field_q <= wr_data[`TCC_CLKS_HI:`TCC_CLKS_LO];
            prescale_field_q <= wr_data[`TCC_PS_HI:`TCC_PS_LO];
        end
    end

    // modulus written straight through, byte lanes by strobe
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            modulus_value_q <= `TCC_CNT_ZERO;
        end else if (wr_mod) begin
            if (wr_strb[0]) begin
                modulus_value_q[`TCC_LO_HI:`TCC_LO_LO] <= wr_data[`TCC_LO_HI:`TCC_LO_LO];
            end
            if (wr_strb[1]) begin
                modulus_value_q[`TCC_HI_HI:`TCC_HI_LO] <= wr_data[`TCC_HI_HI:`TCC_HI_LO];
            end
        end
    end

    // read coherency latch; reads in debug halt leave it alone so a 16-bit
    // read cut by a halt still completes, but control and counter writes always release it
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            latch_valid_q <= 1'b0;
            latch_q <= `TCC_CNT_ZERO;
        end else if (wr_ctrl || wr_cnt) begin
            latch_valid_q <= 1'b0;
        end else if (!debug_halt_i && rd_cnt) begin
            if (!latch_valid_q) begin
                latch_valid_q <= 1'b1;
                latch_q <= count_q;
            end else begin
                latch_valid_q <= 1'b0;
            end
        end
    end

    wire [15:0] cnt_view = latch_valid_q ? latch_q : count_q;
    reg [31:0] rd_word;
    always @* begin
        rd_word = `TCC_WORD_ZERO;
        if (s_axi_araddr == `TCC_ADDR_CTRL) begin
            rd_word[`TCC_LO_HI:`TCC_LO_LO] = {overflow_flag_q, overflow_irq_enable_q,
                center_align_select_q, clock_source_field_q, prescale_field_q};
        end else if (s_axi_araddr == `TCC_ADDR_CNTH) begin
            rd_word[`TCC_LO_HI:`TCC_LO_LO] = cnt_view[`TCC_HI_HI:`TCC_HI_LO];
        end else if (s_axi_araddr == `TCC_ADDR_CNTL) begin
            rd_word[`TCC_LO_HI:`TCC_LO_LO] = cnt_view[`TCC_LO_HI:`TCC_LO_LO];
        end else if (s_axi_araddr == `TCC_ADDR_MOD) begin
            rd_word[`TCC_HI_HI:`TCC_LO_LO] = modulus_value_q;
        end
    end

    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            s_axi_rvalid <= 1'b0;
        end else if (rd_go) begin
            s_axi_rvalid <= 1'b1;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // read data held until the next request so it stands while rvalid is up
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            s_axi_rdata <= `TCC_WORD_ZERO;
            s_axi_rresp <= `TCC_RESP_OKAY;
        end else if (rd_go) begin
            s_axi_rdata <= rd_word;
            s_axi_rresp <= addr_known(s_axi_araddr) ? `TCC_RESP_OKAY : `TCC_RESP_SLVERR;
        end
    end

    // level outputs straight from registers
    assign overflow_irq_o = overflow_flag_q && overflow_irq_enable_q;
    assign count_down_o = down_q;
    assign center_align_o = center_align_select_q;

endmodule

`default_nettype wire

/* File: bench/tcc_timer_core_checker.sv */
// port-level assertions for the timer core
`timescale 1ns/1ps
`default_nettype none
`include "tcc_defs.vh"
module tcc_timer_core_checker (
    input wire mclk_i,
    input wire rst_i,
    input wire overflow_irq_o,
    input wire center_align_o,
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid
);
    // only writes offered with both halves in one cycle are tracked
    wire wr_ctl = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        && s_axi_awaddr == `TCC_ADDR_CTRL && s_axi_wstrb[0];
    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    property p_center;
        wr_ctl |=> center_align_o == $past(s_axi_wdata[`TCC_BIT_CAS]);
    endproperty
    a_center: assert property (p_center) else $error("center select wrong");
    property p_irq_off;
        wr_ctl && !s_axi_wdata[`TCC_BIT_OIE] |=> !overflow_irq_o;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq not masked");
    property p_irq_stay;
        overflow_irq_o && !wr_ctl |=> overflow_irq_o;
    endproperty
    a_irq_stay: assert property (p_irq_stay) else $error("irq dropped");
    property p_reset;
        $fell(rst_i) |-> !overflow_irq_o && !center_align_o;
    endproperty
    a_reset: assert property (p_reset) else $error("reset state wrong");
    property p_bresp;
        wr_ctl |=> s_axi_bvalid && s_axi_bresp == `TCC_RESP_OKAY;
    endproperty
    a_bresp: assert property (p_bresp) else $error("write answer wrong");
    property p_rans;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rans: assert property (p_rans) else $error("read answer late");
    property p_arrefuse;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    a_arrefuse: assert property (p_arrefuse) else $error("read not refused");
    property p_awrefuse;
        s_axi_bvalid |-> !s_axi_awready;
    endproperty
    a_awrefuse: assert property (p_awrefuse) else $error("write not refused");
endmodule
`default_nettype wire

/* File: bench/tcc_timer_core_bench.sv */
// self-checking bench for the timer core
`timescale 1ns/1ps
`default_nettype none
`include "tcc_defs.vh"
module tcc_timer_core_bench;
    logic mclk_i = 1'h0, rst_i = 1'h1, debug_halt_i = 1'h0, fixed_clk_tick_i = 1'h0;
    logic fixed_clk_present_i = 1'h0, ext_clk_i = 1'h0;
    logic overflow_irq_o, count_down_o, center_align_o;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, v, h;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_awready, s_axi_wready;
    logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, br, rr;
    int fails = 0, tests_run = 0, cyc = 0;
    tcc_timer_core i_tcc_timer_core (
        .mclk_i(mclk_i), .rst_i(rst_i), .debug_halt_i(debug_halt_i),
        .fixed_clk_tick_i(fixed_clk_tick_i), .fixed_clk_present_i(fixed_clk_present_i),
        .ext_clk_i(ext_clk_i), .overflow_irq_o(overflow_irq_o), .count_down_o(count_down_o),
        .center_align_o(center_align_o), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready)
    );
    initial forever #2 mclk_i = ~mclk_i;
    // eight bus cycles per period, inside the quarter-rate limit
    initial forever #16 ext_clk_i = ~ext_clk_i;
    task automatic conclude;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        fixed_clk_tick_i <= (cyc % 4 == 0);
        if (cyc == 20000) begin
            fails = fails + 1;
            conclude();
        end
    end
    task automatic chk(input string n, input int lo, hi, input [31:0] g);
        tests_run++;
        if (^g === 1'bx || g < lo || g > hi) begin
            fails++;
            $display("Error %s expected %0d..%0d seen %0d", n, lo, hi, g);
        end
    endtask
    task automatic wr(input [3:0] a, input [31:0] d);
        @(posedge mclk_i);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do @(negedge mclk_i); while (s_axi_awready !== 1'h1 || s_axi_wready !== 1'h1);
        @(posedge mclk_i);
        s_axi_awvalid <= 1'h0;
        s_axi_wvalid <= 1'h0;
        do @(negedge mclk_i); while (s_axi_bvalid !== 1'h1);
        br = s_axi_bresp;
        @(posedge mclk_i);
        s_axi_bready <= 1'h0;
    endtask
    task automatic rd(input [3:0] a);
        @(posedge mclk_i);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do @(negedge mclk_i); while (s_axi_arready !== 1'h1);
        @(posedge mclk_i);
        s_axi_arvalid <= 1'h0;
        do @(negedge mclk_i); while (s_axi_rvalid !== 1'h1);
        v = s_axi_rdata;
        rr = s_axi_rresp;
        @(posedge mclk_i);
        s_axi_rready <= 1'h0;
    endtask
    // prescaler phase is unknown, so counts are checked within a window
    task automatic run(input [7:0] c, input int lo, hi);
        wr(`TCC_ADDR_CTRL, 32'h0);
        wr(`TCC_ADDR_CNTL, 32'h0);
        wr(`TCC_ADDR_CTRL, {24'h0, c});
        repeat (512) @(posedge mclk_i);
        wr(`TCC_ADDR_CTRL, 32'h0);
        rd(`TCC_ADDR_CNTL);
        h = v;
        rd(`TCC_ADDR_CNTH);
        chk("count", lo, hi, {v[7:0], h[7:0]});
    endtask
    initial begin
        repeat (2) @(posedge mclk_i);
        rst_i <= 1'h0;
        for (int a = 0; a < 3; a++) begin
            rd(4'(a * 4));
            chk("reset", 0, 0, v);
        end
        wr(4'h2, 32'h0);
        chk("bresp", `TCC_RESP_SLVERR, `TCC_RESP_SLVERR, br);
        rd(4'h2);
        chk("rresp", `TCC_RESP_SLVERR, `TCC_RESP_SLVERR, rr);
        chk("rdata", 0, 0, v);
        $display("reset test done");
        for (int p = 0; p < 8; p++) run(8'h08 | 8'(p), (512 >> p) - 1, (518 >> p) + 1);
        run(8'h10, 511, 519);
        run(8'h18, 62, 67);
        run(8'h20, 0, 0);
        fixed_clk_present_i <= 1'h1;
        run(8'h10, 126, 131);
        $display("clock test done");
        wr(`TCC_ADDR_CNTH, 32'hFF);
        wr(`TCC_ADDR_CTRL, 32'h08);
        repeat (200) @(posedge mclk_i);
        rd(`TCC_ADDR_CNTH);
        h = v;
        repeat (100) @(posedge mclk_i);
        rd(`TCC_ADDR_CNTL);
        chk("coherent", 200, 212, {h[7:0], v[7:0]});
        debug_halt_i <= 1'h1;
        rd(`TCC_ADDR_CNTL);
        h = v;
        repeat (50) @(posedge mclk_i);
        rd(`TCC_ADDR_CNTL);
        chk("halt", h, h, v);
        debug_halt_i <= 1'h0;
        wr(`TCC_ADDR_CNTL, 32'h0);
        rd(`TCC_ADDR_CNTL);
        h = v;
        repeat (100) @(posedge mclk_i);
        debug_halt_i <= 1'h1;
        rd(`TCC_ADDR_CNTH);
        rd(`TCC_ADDR_CNTL);
        chk("halt latch", h, h, v);
        wr(`TCC_ADDR_CTRL, 32'h08);
        rd(`TCC_ADDR_CNTL);
        chk("halt release", 90, 125, v);
        debug_halt_i <= 1'h0;
        $display("counter test done");
        wr(`TCC_ADDR_CTRL, 32'h0);
        wr(`TCC_ADDR_MOD, 32'h0F);
        wr(`TCC_ADDR_CNTL, 32'h0);
        wr(`TCC_ADDR_CTRL, 32'h48);
        repeat (40) @(posedge mclk_i);
        wr(`TCC_ADDR_CTRL, 32'h40);
        rd(`TCC_ADDR_CTRL);
        chk("flag", 'hC0, 'hC0, v);
        chk("irq", 1, 1, overflow_irq_o);
        wr(`TCC_ADDR_CTRL, 32'hC0);
        rd(`TCC_ADDR_CTRL);
        chk("flag", 'hC0, 'hC0, v);
        wr(`TCC_ADDR_CTRL, 32'h40);
        rd(`TCC_ADDR_CTRL);
        chk("flag", 'h40, 'h40, v);
        chk("irq", 0, 0, overflow_irq_o);
        wr(`TCC_ADDR_CTRL, 32'h08);
        repeat (40) @(posedge mclk_i);
        rd(`TCC_ADDR_CTRL);
        repeat (40) @(posedge mclk_i);
        wr(`TCC_ADDR_CTRL, 32'h0);
        rd(`TCC_ADDR_CTRL);
        chk("flag", 'h80, 'h80, v);
        $display("overflow test done");
        wr(`TCC_ADDR_CTRL, 32'h0);
        wr(`TCC_ADDR_CNTL, 32'h0);
        wr(`TCC_ADDR_CTRL, 32'h28);
        repeat (20) @(posedge mclk_i);
        @(negedge mclk_i);
        chk("down", 1, 1, count_down_o);
        repeat (40) @(posedge mclk_i);
        rd(`TCC_ADDR_CTRL);
        chk("center flag", 'hA8, 'hA8, v);
        $display("center test done");
        conclude();
    end
endmodule
bind tcc_timer_core tcc_timer_core_checker i_tcc_timer_core_checker (
    .mclk_i(mclk_i), .rst_i(rst_i), .overflow_irq_o(overflow_irq_o),
    .center_align_o(center_align_o), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid)
);
`default_nettype wire
